// File: pkg/batt_setup_pkg.sv
// Constants, register indices and types for the setup and status bank.
package batt_setup_pkg;

  // Clock period and derived pulse timing.
  localparam int unsigned CLK_PERIOD_NS  = 50;
  localparam int unsigned SHORT_PULSE_NS = 1000;
  localparam int unsigned SHORT_PULSE_CYC =
    (SHORT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register indices; the byte address is four times the index.
  localparam logic [7:0] IDX_SETUP_FIRST   = 8'h92;
  localparam logic [7:0] IDX_SETUP_SECOND  = 8'h93;
  localparam logic [7:0] IDX_SCRATCH_ONE   = 8'h94;
  localparam logic [7:0] IDX_SCRATCH_TWO   = 8'h95;
  localparam logic [7:0] IDX_LINK_STATE    = 8'h96;
  localparam logic [7:0] IDX_SERIAL_LOW    = 8'h97;
  localparam logic [7:0] IDX_SERIAL_MID    = 8'h98;
  localparam logic [7:0] IDX_SERIAL_HIGH   = 8'h99;
  localparam logic [7:0] IDX_NOMINAL_VOLT  = 8'h9a;
  localparam logic [7:0] IDX_FAULT_SUPPR   = 8'h9b;
  localparam logic [7:0] IDX_STORED_SIG    = 8'h9c;
  localparam logic [7:0] IDX_COMPUTED_SIG  = 8'h9d;
  localparam logic [7:0] IDX_SIG_UPPER     = 8'h9e;

  // Field positions in the second setup register.
  localparam int unsigned POS_CELL_AVG   = 0;
  localparam int unsigned POS_TEMP_AVG   = 3;
  localparam int unsigned POS_G1_VALUE   = 6;
  localparam int unsigned POS_G2_VALUE   = 7;
  localparam int unsigned POS_G2_SELECT  = 8;
  localparam int unsigned POS_PORT_OFF   = 12;
  localparam int unsigned POS_TEMP_MUX   = 13;
  localparam int unsigned POS_FORCE_POS  = 14;
  localparam int unsigned POS_FORCE_NEG  = 15;

  // Field positions in the first setup register.
  localparam int unsigned POS_G1_DIR     = 0;
  localparam int unsigned POS_G2_DIR     = 1;
  localparam int unsigned POS_G1_SPECIAL = 2;
  localparam int unsigned POS_G2_SPECIAL = 3;

  // Special-function select codes for the second GPIO.
  localparam logic [3:0] G2SEL_VALUE = 4'h0;
  localparam logic [3:0] G2SEL_SHORT = 4'h1;
  localparam logic [3:0] G2SEL_LONG  = 4'h2;

  // Forced ADC readings.
  localparam logic [15:0] CELL_FORCE_POS = 16'h7ffc;
  localparam logic [15:0] TEMP_FORCE_POS = 16'hfffc;
  localparam logic [15:0] CELL_FORCE_NEG = 16'h8000;
  localparam logic [15:0] TEMP_FORCE_NEG = 16'h0000;

  // Reset values and signature settings.
  localparam logic [15:0] RST_WORD      = 16'h0000;
  localparam logic [23:0] SIG_SEED      = 24'h00_0000;
  localparam logic [23:0] SIG_POLY      = 24'h80_0057;
  localparam logic [2:0]  SIG_LAST_WORD = 3'h7;

  // Signature walk states.
  typedef enum logic {WALK_IDLE, WALK_RUN} walk_state_t;

endpackage : batt_setup_pkg

// File: src/batt_setup_regs.sv
// Setup and status register bank of the battery monitor, on APB.
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////
// Summary of operation
// [RL1] GPIO1 output pin follows its drive value; with its special enable set the code drives the inverted fault summary
// [RL2] GPIO2 normal or fallback uses drive value
// [RL3] GPIO2 select: value, short pulse, long pulse
// [RL4] Two 16-bit scratch registers, no effect except on the signature walk
// [RL5] Scratch registers feed the signature walk
// [RL6] Stack size taken from roll-call result
// [RL7] Stack size read-only, exported for link use
// [RL8] Serial number mirrored, lowest word lowest address
// [RL9] Serial number readable, writes ignored
// [RL10] Per-cell mask suppresses cell 2-14 faults
// [RL11] Mask one disables, zero keeps testing
// [RL12] Cell one faults never masked
// [RL13] Signature recomputed on each nonvolatile load
// [RL14] Computed signature must equal stored signature
// [RL15] Comparison repeated every scan, both readable
// [RL16] Low words separate, upper bytes shared
// [RL17] Special enable routes selected signal to GPIO2
// [RL18] Direction bit: zero input, one output
// [RL19] Force bits replace cell and temperature readings
// [RL20] Port-disable bit turns upper chain port off
module batt_setup_regs (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        nv_load,
  input  wire logic [47:0] nv_serial,
  input  wire logic [7:0]  nv_nominal,
  input  wire logic [23:0] nv_signature,
  input  wire logic        scan_start,
  input  wire logic        roll_call_done,
  input  wire logic [4:0]  roll_call_size,
  input  wire logic [4:0]  device_address,
  input  wire logic        link_kind_pin,
  input  wire logic [1:0]  chain_bit_rate_pin,
  input  wire logic        data_ready_pin,
  input  wire logic        fault_any,
  input  wire logic        meas_start,
  input  wire logic        meas_active,
  input  wire logic [15:0] cell_reading_raw,
  input  wire logic [15:0] temp_reading_raw,
  input  wire logic [13:0] ov_raw,
  input  wire logic [13:0] uv_raw,
  output logic             gpio1_out,
  output logic             gpio1_oe,
  output logic             gpio2_out,
  output logic             gpio2_oe,
  output logic             upper_chain_port_disable,
  output logic      [2:0]  cell_averaging_setting,
  output logic      [2:0]  temp_averaging_setting,
  output logic             temp_mux_control,
  output logic      [15:0] cell_reading,
  output logic      [15:0] temp_reading,
  output logic      [13:0] ov_fault,
  output logic      [13:0] uv_fault,
  output logic      [4:0]  stack_size,
  output logic             signature_match
);

  //////////////////////////////////////////////////////////////////////////
  // State of the whole block, held as one record.
  typedef struct packed {
    logic [15:0] setup_second;   // Averaging, GPIO values, test bits.
    logic [3:0]  setup_first;    // GPIO direction and special enables.
    logic [15:0] scratch_one;    // User data, no effect except on the signature walk.
    logic [15:0] scratch_two;    // User data, no effect except on the signature walk.
    logic [13:0] suppress;       // Per-cell fault suppress bits.
    logic [4:0]  size;           // Stack size from roll call.
    logic [4:0]  address;        // Device address copy.
    logic [47:0] serial;         // Serial number mirror.
    logic [7:0]  nominal;        // Nominal cell voltage code.
    logic [23:0] stored_sig;     // Factory signature.
    logic [23:0] computed_sig;   // Signature built from the shadow words.
    logic        match;          // Last comparison result.
    batt_setup_pkg::walk_state_t walk;
    logic [2:0]  walk_idx;       // Word being folded into the signature.
    logic [3:0]  pin_s1;         // Pin synchroniser, first stage.
    logic [3:0]  pin_s2;         // Pin synchroniser, second stage.
    logic [3:0]  pin_s3;         // Pin synchroniser, third stage.
    logic [3:0]  pin_stable;     // Accepted pin levels.
    logic [4:0]  pulse_cnt;      // Remaining short-pulse cycles.
    logic        g1_out;
    logic        g1_oe;
    logic        g2_out;
    logic        g2_oe;
    logic [15:0] cell_rd;
    logic [15:0] temp_rd;
    logic [13:0] ov_f;
    logic [13:0] uv_f;
    logic [31:0] rdata;
    logic        ready;
    logic        err;
  } state_t;

  state_t q;  // Registered state.
  state_t d;  // Next state.

  //////////////////////////////////////////////////////////////////////////
  // Decoding helpers.

  // True for an index that names a register of this bank.
  function automatic logic is_mapped(input logic [7:0] idx);
    is_mapped = (idx >= batt_setup_pkg::IDX_SETUP_FIRST) &&
                (idx <= batt_setup_pkg::IDX_SIG_UPPER);
  endfunction : is_mapped

  // Word folded into the signature at each step of the walk.
  function automatic logic [15:0] shadow_word(input state_t s,
                                              input logic [2:0] i);
    unique case (i)
      3'h0:    shadow_word = s.setup_second;
      3'h1:    shadow_word = s.scratch_one;   // [RL5]
      3'h2:    shadow_word = s.scratch_two;   // [RL5]
      3'h3:    shadow_word = {2'b00, s.suppress};
      3'h4:    shadow_word = {8'h00, s.nominal};
      3'h5:    shadow_word = s.serial[15:0];
      3'h6:    shadow_word = s.serial[31:16];
      default: shadow_word = s.serial[47:32];
    endcase
  endfunction : shadow_word

  // One step of the multiple-input signature register.
  function automatic logic [23:0] sig_step(input logic [23:0] sig,
                                           input logic [15:0] w);
    sig_step = {sig[22:0], 1'b0} ^ (sig[23] ? batt_setup_pkg::SIG_POLY
                                             : 24'h00_0000) ^ {8'h00, w};
  endfunction : sig_step

  // Read value of a register; unmapped indices read zero.
  function automatic logic [15:0] read_word(input state_t s,
                                            input logic [7:0] idx);
    read_word = 16'h0000;
    unique case (idx)
      batt_setup_pkg::IDX_SETUP_FIRST:  read_word = {12'h000, s.setup_first};
      batt_setup_pkg::IDX_SETUP_SECOND: read_word = s.setup_second;
      batt_setup_pkg::IDX_SCRATCH_ONE:  read_word = s.scratch_one;
      batt_setup_pkg::IDX_SCRATCH_TWO:  read_word = s.scratch_two;
      // Rate, kind and data-ready come from synchronised pins.
      batt_setup_pkg::IDX_LINK_STATE:   read_word = {s.pin_stable[2:1], 1'b0,
        s.pin_stable[0], s.size, s.address, 1'b1, s.pin_stable[3]}; // [RL7]
      batt_setup_pkg::IDX_SERIAL_LOW:   read_word = s.serial[15:0];  // [RL8]
      batt_setup_pkg::IDX_SERIAL_MID:   read_word = s.serial[31:16]; // [RL8]
      batt_setup_pkg::IDX_SERIAL_HIGH:  read_word = s.serial[47:32]; // [RL8]
      batt_setup_pkg::IDX_NOMINAL_VOLT: read_word = {8'h00, s.nominal};
      batt_setup_pkg::IDX_FAULT_SUPPR:  read_word = {2'b00, s.suppress};
      batt_setup_pkg::IDX_STORED_SIG:   read_word = s.stored_sig[15:0];
      batt_setup_pkg::IDX_COMPUTED_SIG: read_word = s.computed_sig[15:0];
      batt_setup_pkg::IDX_SIG_UPPER:    read_word =
        {s.stored_sig[23:16], s.computed_sig[23:16]};             // [RL16]
      default:                          read_word = 16'h0000;
    endcase
  endfunction : read_word

  //////////////////////////////////////////////////////////////////////////
  // Bus decode shared by the next-state logic.
  logic [7:0] bus_idx;     // Word index of the current access.
  logic       bus_ok;      // Aligned and mapped.
  logic       wr_fire;     // Write completing at this edge.
  logic [15:0] wdat;       // Low half of write data.

  assign bus_idx = paddr[9:2];
  assign bus_ok  = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00) &&
                   is_mapped(bus_idx);
  assign wr_fire = psel && penable && pwrite && q.ready && !q.err;
  assign wdat    = pwdata[15:0];

  //////////////////////////////////////////////////////////////////////////
  // Next-state logic for the whole bank.
  always_comb
  begin
    logic [3:0] pins_now;
    logic       g2_sel_sig;
    pins_now   = {data_ready_pin, chain_bit_rate_pin, link_kind_pin};
    g2_sel_sig = 1'b0;
    d = q;

    // The access phase waits one cycle so that every output is a flop.
    d.ready = psel && penable && !q.ready;
    d.err   = psel && penable && !q.ready && !bus_ok;
    if (psel && penable && !q.ready)
    begin
      d.rdata = bus_ok ? {16'h0000, read_word(q, bus_idx)} : 32'h0000_0000;
    end

    // Writes land on the edge where pready is sampled high.
    if (wr_fire)
    begin
      unique case (bus_idx)
        batt_setup_pkg::IDX_SETUP_FIRST:  d.setup_first  = wdat[3:0];
        batt_setup_pkg::IDX_SETUP_SECOND: d.setup_second = wdat;
        batt_setup_pkg::IDX_SCRATCH_ONE:  d.scratch_one  = wdat; // [RL4]
        batt_setup_pkg::IDX_SCRATCH_TWO:  d.scratch_two  = wdat; // [RL4]
        batt_setup_pkg::IDX_FAULT_SUPPR:  d.suppress     = wdat[13:0];
        // Read-only registers, serial words among them, ignore writes.
        default:                          d = d;                 // [RL9]
      endcase
    end

    // Stack size is taken from each completed roll call.
    if (roll_call_done)
    begin
      d.size = roll_call_size;                                   // [RL6]
    end
    d.address = device_address;

    // Pins: a new level counts once the second and third stages agree.
    d.pin_s1 = pins_now;
    d.pin_s2 = q.pin_s1;
    d.pin_s3 = q.pin_s2;
    for (int b = 0; b < 4; b++)
    begin
      if (q.pin_s2[b] == q.pin_s3[b])
      begin
        d.pin_stable[b] = q.pin_s3[b];
      end
    end

    // Nonvolatile load refreshes the mirrors and restarts the walk.
    if (nv_load)
    begin
      d.serial       = nv_serial;                                // [RL8]
      d.nominal      = nv_nominal;
      d.stored_sig   = nv_signature;
      d.computed_sig = batt_setup_pkg::SIG_SEED;                 // [RL13]
      d.walk         = batt_setup_pkg::WALK_RUN;
      d.walk_idx     = 3'h0;
    end
    else
    begin
      unique case (q.walk)
        batt_setup_pkg::WALK_IDLE:
        begin
          // Each scan repeats the comparison on the current values.
          if (scan_start)
          begin
            d.match = (q.computed_sig == q.stored_sig);          // [RL15]
          end
        end
        batt_setup_pkg::WALK_RUN:
        begin
          // One shadow word is folded in per cycle.
          d.computed_sig = sig_step(q.computed_sig,
                                    shadow_word(q, q.walk_idx)); // [RL13]
          d.walk_idx = q.walk_idx + 3'h1;
          if (q.walk_idx == batt_setup_pkg::SIG_LAST_WORD)
          begin
            d.walk  = batt_setup_pkg::WALK_IDLE;
            d.match = (d.computed_sig == q.stored_sig);          // [RL14]
          end
        end
      endcase
    end

    // Short pulse counter restarts at every measurement start.
    if (meas_start)
    begin
      d.pulse_cnt = 5'(batt_setup_pkg::SHORT_PULSE_CYC);
    end
    else if (q.pulse_cnt != 5'h00)
    begin
      d.pulse_cnt = q.pulse_cnt - 5'h01;
    end

    // GPIO1: special output is the inverted fault summary.
    d.g1_oe  = q.setup_first[batt_setup_pkg::POS_G1_DIR];      // [RL18]
    d.g1_out = q.setup_first[batt_setup_pkg::POS_G1_SPECIAL] ? !fault_any
             : q.setup_second[batt_setup_pkg::POS_G1_VALUE];   // [RL1]

    // GPIO2: unknown select codes fall back to the drive value.
    unique case (q.setup_second[batt_setup_pkg::POS_G2_SELECT +: 4])
      batt_setup_pkg::G2SEL_SHORT: g2_sel_sig = (q.pulse_cnt != 5'h00);
      batt_setup_pkg::G2SEL_LONG:  g2_sel_sig = meas_active;    // [RL3]
      default: g2_sel_sig = q.setup_second[batt_setup_pkg::POS_G2_VALUE];
    endcase
    d.g2_oe  = q.setup_first[batt_setup_pkg::POS_G2_DIR];      // [RL18]
    d.g2_out = q.setup_first[batt_setup_pkg::POS_G2_SPECIAL] ? g2_sel_sig
             : q.setup_second[batt_setup_pkg::POS_G2_VALUE];   // [RL2] [RL17]

    // Forced readings; with both bits set positive wins, unsupported.
    if (q.setup_second[batt_setup_pkg::POS_FORCE_POS])
    begin
      d.cell_rd = batt_setup_pkg::CELL_FORCE_POS;              // [RL19]
      d.temp_rd = batt_setup_pkg::TEMP_FORCE_POS;
    end
    else if (q.setup_second[batt_setup_pkg::POS_FORCE_NEG])
    begin
      d.cell_rd = batt_setup_pkg::CELL_FORCE_NEG;              // [RL19]
      d.temp_rd = batt_setup_pkg::TEMP_FORCE_NEG;
    end
    else
    begin
      d.cell_rd = cell_reading_raw;
      d.temp_rd = temp_reading_raw;
    end

    // Fault suppression; cell one always passes.
    d.ov_f = ov_raw & ~{q.suppress[13:1], 1'b0};               // [RL10] [RL11]
    d.uv_f = uv_raw & ~{q.suppress[13:1], 1'b0};               // [RL12]
  end

  //////////////////////////////////////////////////////////////////////////
  // State register; every field resets to a constant.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs, each straight from the state register.
  assign prdata                   = q.rdata;
  assign pready                   = q.ready;
  assign pslverr                  = q.err;
  assign gpio1_out                = q.g1_out;
  assign gpio1_oe                 = q.g1_oe;
  assign gpio2_out                = q.g2_out;
  assign gpio2_oe                 = q.g2_oe;
  assign upper_chain_port_disable =
    q.setup_second[batt_setup_pkg::POS_PORT_OFF];              // [RL20]
  assign cell_averaging_setting   =
    q.setup_second[batt_setup_pkg::POS_CELL_AVG +: 3];
  assign temp_averaging_setting   =
    q.setup_second[batt_setup_pkg::POS_TEMP_AVG +: 3];
  assign temp_mux_control         =
    q.setup_second[batt_setup_pkg::POS_TEMP_MUX];
  assign cell_reading             = q.cell_rd;
  assign temp_reading             = q.temp_rd;
  assign ov_fault                 = q.ov_f;
  assign uv_fault                 = q.uv_f;
  assign stack_size               = q.size;                    // [RL7]
  assign signature_match          = q.match;

  //////////////////////////////////////////////////////////////////////////
  // Checks on the behaviour above.
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_gpio1_value: assert property ( // [RL1]
    (q.g1_oe && !q.setup_first[batt_setup_pkg::POS_G1_SPECIAL])
    |=> gpio1_out == $past(q.setup_second[batt_setup_pkg::POS_G1_VALUE]))
    else $error("GPIO1 does not follow its drive value");

  a_gpio2_long: assert property ( // [RL3]
    (q.setup_first[batt_setup_pkg::POS_G2_SPECIAL] &&
     q.setup_second[batt_setup_pkg::POS_G2_SELECT +: 4] == 4'h2)
    |=> gpio2_out == $past(meas_active))
    else $error("GPIO2 long pulse does not track the measurement");

  a_gpio_dir: assert property ( // [RL18]
    !q.setup_first[batt_setup_pkg::POS_G1_DIR] |=> !gpio1_oe)
    else $error("GPIO1 driven while set as input");

  a_scratch_write: assert property ( // [RL4]
    (wr_fire && bus_idx == batt_setup_pkg::IDX_SCRATCH_ONE)
    |=> q.scratch_one == $past(pwdata[15:0]))
    else $error("Scratch write lost");

  a_serial_ro: assert property ( // [RL9]
    (wr_fire && bus_idx == batt_setup_pkg::IDX_SERIAL_LOW && !nv_load)
    |=> $stable(q.serial))
    else $error("Serial number changed by a write");

  a_cell_one: assert property ( // [RL12]
    (ov_raw[0] && q.suppress[0]) |=> ov_fault[0])
    else $error("Cell one fault was masked");

  a_mask_cell: assert property ( // [RL11]
    (q.suppress[5] && ov_raw[5]) |=> !ov_fault[5])
    else $error("Masked cell fault passed");

  a_size_roll: assert property ( // [RL6]
    roll_call_done |=> stack_size == $past(roll_call_size))
    else $error("Stack size not taken from roll call");

  a_force_pos: assert property ( // [RL19]
    q.setup_second[batt_setup_pkg::POS_FORCE_POS] |=>
      cell_reading == 16'h7ffc && temp_reading == 16'hfffc)
    else $error("Forced positive reading wrong");

  a_walk_done: assert property ( // [RL13]
    (nv_load ##1 !nv_load [*8]) |=> q.walk == batt_setup_pkg::WALK_IDLE)
    else $error("Signature walk did not finish in eight cycles");

endmodule : batt_setup_regs

// File: test/nv_source_model.sv
// Model of the nonvolatile store that loads the shadow registers.
`timescale 1ns/100ps
module nv_source_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        go,
  input  wire logic [47:0] serial_in,
  input  wire logic [7:0]  nominal_in,
  input  wire logic [23:0] sig_in,
  output logic             nv_load,
  output logic      [47:0] nv_serial,
  output logic      [7:0]  nv_nominal,
  output logic      [23:0] nv_signature
);
  // One load pulse per request; data is valid only at the pulse edge.
  // Afterwards the lines show inverted data, so a late sampler is caught.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      nv_load      <= 1'b0;
      nv_serial    <= 48'h0000_0000_0000;
      nv_nominal   <= 8'h00;
      nv_signature <= 24'h00_0000;
    end
    else if (go && !nv_load)
    begin
      nv_load      <= 1'b1;
      nv_serial    <= serial_in;
      nv_nominal   <= nominal_in;
      nv_signature <= sig_in;
    end
    else if (nv_load)
    begin
      nv_load      <= 1'b0;
      nv_serial    <= ~nv_serial;
      nv_nominal   <= ~nv_nominal;
      nv_signature <= ~nv_signature;
    end
  end
endmodule : nv_source_model

// File: test/tb_batt_setup_regs.sv
// Self-checking bench for the setup and status register bank.
`timescale 1ns/100ps
module tb_batt_setup_regs;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, nv_load, nv_go = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic [47:0] nv_serial;
  logic [7:0]  nv_nominal;
  logic [23:0] nv_signature, sig_in = 24'h00_0000;
  logic scan_start = 1'b0, roll_call_done = 1'b0, meas_start = 1'b0;
  logic meas_active = 1'b0, fault_any = 1'b0;
  logic link_kind_pin = 1'b1, data_ready_pin = 1'b1;
  logic [1:0]  chain_bit_rate_pin = 2'h2;
  logic [4:0]  roll_call_size = 5'h00, device_address = 5'h03, stack_size;
  logic [15:0] cell_reading_raw = 16'h1111, temp_reading_raw = 16'h2222;
  logic [15:0] cell_reading, temp_reading;
  logic [13:0] ov_raw = 14'h3fff, uv_raw = 14'h3fff, ov_fault, uv_fault;
  logic gpio1_out, gpio1_oe, gpio2_out, gpio2_oe, signature_match;
  logic upper_chain_port_disable, temp_mux_control;
  logic [2:0]  cell_averaging_setting, temp_averaging_setting;
  int          mismatches = 0;
  int          cmp_count = 0;

  // The 20 MHz bus clock.
  always #25 pclk = ~pclk;

  batt_setup_regs dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .nv_load, .nv_serial, .nv_nominal,
    .nv_signature, .scan_start, .roll_call_done, .roll_call_size,
    .device_address, .link_kind_pin, .chain_bit_rate_pin, .data_ready_pin,
    .fault_any, .meas_start, .meas_active, .cell_reading_raw,
    .temp_reading_raw, .ov_raw, .uv_raw, .gpio1_out, .gpio1_oe, .gpio2_out,
    .gpio2_oe, .upper_chain_port_disable, .cell_averaging_setting,
    .temp_averaging_setting, .temp_mux_control, .cell_reading,
    .temp_reading, .ov_fault, .uv_fault, .stack_size, .signature_match);

  nv_source_model nv (.pclk, .presetn, .go(nv_go),
    .serial_in(48'ha5a5_3c3c_0f0f), .nominal_in(8'h32), .sig_in,
    .nv_load, .nv_serial, .nv_nominal, .nv_signature);

  ////////////////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then ends the run.
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  // One comparison; an unknown never matches.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  // One APB transfer; held until pready is seen high at a rising edge.
  task automatic apb(input logic wr, input logic [7:0] idx,
                     input logic [15:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= {16'h0000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      mismatches++;
      test_done();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [15:0] wd);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, idx, wd, rd, err);
  endtask : wr

  // Reads a register and expects a clean answer with this value.
  task automatic rdchk(input logic [7:0] idx, input logic [15:0] exp);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, idx, 16'h0000, rd, err);
    chk({err, rd[30:0]}, {16'h0000, exp});
  endtask : rdchk

  // One signature step: shift, fold the top bit back, add the word.
  function automatic logic [23:0] step(input logic [23:0] s,
                                       input logic [15:0] w);
    step = {s[22:0], 1'b0} ^ {8'h00, w} ^
           (s[23] ? batt_setup_pkg::SIG_POLY : 24'h00_0000);
  endfunction : step

  ////////////////////////////////////////////////////////////////////////
  // Main sequence of scenarios.
  initial
  begin
    logic [15:0] w [8];
    logic [7:0]  zi [5];
    logic [23:0] sig;
    logic [31:0] rd;
    logic        err;
    w = '{16'h0000, 16'h1234, 16'hbeef, 16'h0000, 16'h0032, 16'h0f0f,
          16'h3c3c, 16'ha5a5};
    zi = '{8'h92, 8'h93, 8'h94, 8'h95, 8'h9b};
    cyc(16);
    presetn <= 1'b1;
    foreach (zi[i]) rdchk(zi[i], 16'h0000);
    // A scan before any load compares the two reset values, which agree.
    scan_start <= 1'b1;
    cyc(1);
    scan_start <= 1'b0;
    cyc(2);
    chk({31'h0, signature_match}, 32'h0000_0001);
    wr(8'h94, 16'h1234);
    wr(8'h95, 16'hbeef);
    rdchk(8'h94, 16'h1234);
    rdchk(8'h95, 16'hbeef);
    // Expected signature over the walk order, fed as the stored value.
    sig = batt_setup_pkg::SIG_SEED;
    foreach (w[i]) sig = step(sig, w[i]);
    sig_in <= sig;
    nv_go  <= 1'b1;
    cyc(1);
    nv_go  <= 1'b0;
    cyc(14);
    chk({31'h0, signature_match}, 32'h0000_0001);
    rdchk(8'h97, 16'h0f0f);
    rdchk(8'h98, 16'h3c3c);
    rdchk(8'h99, 16'ha5a5);
    rdchk(8'h9a, 16'h0032);
    rdchk(8'h9d, sig[15:0]);
    rdchk(8'h9e, {sig[23:16], sig[23:16]});
    wr(8'h97, 16'hffff);
    rdchk(8'h97, 16'h0f0f);
    // A corrupted stored value must fail, also when rescanned.
    sig_in <= sig ^ 24'h00_0001;
    nv_go  <= 1'b1;
    cyc(1);
    nv_go  <= 1'b0;
    cyc(14);
    scan_start <= 1'b1;
    cyc(1);
    scan_start <= 1'b0;
    cyc(4);
    chk({31'h0, signature_match}, 32'h0000_0000);
    rdchk(8'h9c, sig[15:0] ^ 16'h0001);
    apb(1'b0, 8'h9f, 16'h0000, rd, err);
    chk({err, rd[30:0]}, 32'h8000_0000);
    // GPIO paths: plain value, fallback, long and short pulses.
    wr(8'h92, 16'h0001);
    wr(8'h93, 16'h0040);
    cyc(3);
    chk({30'h0, gpio1_oe, gpio1_out}, 32'h0000_0003);
    wr(8'h93, 16'h0000);
    cyc(3);
    chk({30'h0, gpio1_oe, gpio1_out}, 32'h0000_0002);
    wr(8'h92, 16'h0005);
    cyc(3);
    chk({30'h0, gpio1_oe, gpio1_out}, 32'h0000_0003);
    fault_any <= 1'b1;
    cyc(3);
    chk({30'h0, gpio1_oe, gpio1_out}, 32'h0000_0002);
    wr(8'h92, 16'h0002);
    wr(8'h93, 16'h0080);
    cyc(3);
    chk({29'h0, gpio1_oe, gpio2_oe, gpio2_out}, 32'h0000_0003);
    wr(8'h92, 16'h000a);
    wr(8'h93, 16'h0380);
    cyc(3);
    chk({31'h0, gpio2_out}, 32'h0000_0001);
    wr(8'h93, 16'h0200);
    meas_active <= 1'b1;
    cyc(3);
    chk({31'h0, gpio2_out}, 32'h0000_0001);
    meas_active <= 1'b0;
    cyc(3);
    chk({31'h0, gpio2_out}, 32'h0000_0000);
    wr(8'h93, 16'h0100);
    meas_start <= 1'b1;
    cyc(1);
    meas_start <= 1'b0;
    cyc(3);
    chk({31'h0, gpio2_out}, 32'h0000_0001);
    cyc(batt_setup_pkg::SHORT_PULSE_CYC - 2);
    chk({31'h0, gpio2_out}, 32'h0000_0001);
    cyc(1);
    chk({31'h0, gpio2_out}, 32'h0000_0000);
    wr(8'h92, 16'h0000);
    cyc(3);
    chk({30'h0, gpio1_oe, gpio2_oe}, 32'h0000_0000);
    // Fault suppression: cell one stays live even when its bit is set.
    wr(8'h9b, 16'hffff);
    cyc(3);
    chk({4'h0, ov_fault, uv_fault}, 32'h0000_4001);
    wr(8'h9b, 16'h0004);
    cyc(3);
    chk({4'h0, ov_fault, uv_fault}, 32'h0ffe_fffb);
    // Setup fields, port disable and forced readings.
    wr(8'h93, 16'h702d);
    cyc(3);
    chk({24'h0, upper_chain_port_disable, temp_mux_control,
         temp_averaging_setting, cell_averaging_setting},
        32'h0000_00ed);
    chk({cell_reading, temp_reading}, 32'h7ffc_fffc);
    wr(8'h93, 16'h8000);
    cyc(3);
    chk({cell_reading, temp_reading}, 32'h8000_0000);
    wr(8'h93, 16'h0000);
    cyc(3);
    chk({cell_reading, temp_reading}, 32'h1111_2222);
    // Roll call sets the stack size, read-only in the link state.
    roll_call_size <= 5'h07;
    roll_call_done <= 1'b1;
    cyc(1);
    roll_call_done <= 1'b0;
    cyc(3);
    chk({27'h0, stack_size}, 32'h0000_0007);
    wr(8'h96, 16'h0000);
    rdchk(8'h96, 16'h938f);
    test_done();
  end
endmodule : tb_batt_setup_regs
